// ---- hw/cmd_decode.sv ----
/*
  Decodes the command code of the first control word.
  Assumes the word comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module cmd_decode
  import drive_pkg::*;
(
  input  wire logic [15:0] control_word,
  output var  cmd_e        command
);
`include "drive_cfg.svh"

  // ****************************************************************
  // command code
  // ****************************************************************
  // coast outranks quick stop, quick stop outranks the rest
  always_comb begin
    if (!control_word[`DRV_CW_ACCEPT_BIT]) begin
      command = cmd_none;
    end else if (!control_word[`DRV_CW_NOCOAST_BIT]) begin // [RQ6]
      command = cmd_coast;
    end else if (!control_word[`DRV_CW_NOQUICK_BIT]) begin // [RQ7]
      command = cmd_quick;
    end else if (!control_word[`DRV_CW_SWITCH_BIT]) begin // [RQ1]
      command = cmd_off;
    end else if (!control_word[`DRV_CW_ENOP_BIT]) begin
      command = cmd_on;
    end else begin
      command = cmd_enable_op;
    end
  end

endmodule : cmd_decode

`default_nettype wire

// ---- hw/drive_cfg.svh ----
/*
  Constants of the drive control link and of the controller's register map.
  Assumes inclusion by bare name from hw/ design files.
*/
`ifndef DRIVE_CFG_SVH
`define DRIVE_CFG_SVH

// ****************************************************************
// control word layout
// ****************************************************************
`define DRV_CW_SWITCH_BIT   0
`define DRV_CW_NOCOAST_BIT  1
`define DRV_CW_NOQUICK_BIT  2
`define DRV_CW_ENOP_BIT     3
`define DRV_CW_ACCEPT_BIT   10
`define DRV_CW_BASE         16'h0400
`define DRV_CW_RESET        16'h0400

// ****************************************************************
// status word patterns
// ****************************************************************
`define DRV_ST_MASK         16'h0277
`define DRV_ST_LOCKED       16'h0240
`define DRV_ST_READY        16'h0201
`define DRV_ST_SWITCHED     16'h0203
`define DRV_ST_OPERATION    16'h0207
`define DRV_ST_COAST        16'h0250
`define DRV_ST_COAST_QUICK  16'h0270
`define DRV_ST_QUICK        16'h0260
`define DRV_ST_FAULT        16'h0008
`define DRV_ST_RESET        16'h0240

// ****************************************************************
// controller register map and bus answers
// ****************************************************************
`define CTL_REG_CMD         4'h0
`define CTL_REG_STATUS      4'h4
`define CTL_REG_SEQ         4'h8
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ---- hw/drive_device.sv ----
/*
  Drive end: device-control state machine, status word, power stage,
  controller enable and automatic brake.
  Assumes a fieldbus master on the link that writes control words and
  polls the status word; enable and fault inputs come from pins.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
// Notes on behaviour
// [RQ1] low four control bits form command code
// [RQ2] off command from locked enters ready
// [RQ3] on command enables power stage, switched on
// [RQ4] enable operation enters operation, controller enabled
// [RQ5] disable returns switched on; off returns ready
// [RQ6] bit1 clear coasts, power stage disabled
// [RQ7] bit2 clear quick stops, controller disabled
// [RQ8] locked state reports 0x0240
// [RQ9] masked status bits identify the state
// [RQ10] master waits for expected masked status
// [RQ11] master keeps other upper bits clear
// [RQ12] master enables with 0406, 0407, 040f
// [RQ13] power stage off engages brake
// [RQ14] power stage on releases brake
// [RQ15] enabled stage runs the selected mode
// [RQ16] master always sets control bit 10
// [RQ17] any fault leads to locked state
// [RQ18] ready waits for both enable inputs
// [RQ19] unmatched command leaves state unchanged
`timescale 1ns/1ns
`default_nettype none

module drive_device
  import drive_pkg::*;
#(
  parameter int MODE_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  drive_link_if.device           link,
  input  wire logic              power_enable_pin,
  input  wire logic              controller_enable_pin,
  input  wire logic              fault_pin,
  input  wire logic [MODE_W-1:0] op_mode,
  output var  logic              power_stage_on,
  output var  logic              controller_on,
  output var  logic              brake_engaged,
  output var  logic [MODE_W-1:0] active_mode,
  output var  drive_state_e      drive_state
);
`include "drive_cfg.svh"

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic       enables_ok;
  logic       fault_seen;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 3'h0;
    end else begin
      pin_meta_q <= {fault_pin, controller_enable_pin, power_enable_pin};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 3'h0;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  assign enables_ok = pin_sync_q[0] & pin_sync_q[1]; // [RQ18]
  assign fault_seen = pin_sync_q[2];

  // ****************************************************************
  // command decode
  // ****************************************************************
  cmd_e command;

  // upper bits other than the accept bit are not looked at
  cmd_decode u_decode (
    .control_word (link.control_word), // [RQ11] [RQ16]
    .command      (command)
  );

  // ****************************************************************
  // state machine
  // ****************************************************************
  drive_state_e state_q;
  drive_state_e state_d;
  logic         coast_quick_q;
  logic         coast_quick_d;

  always_comb begin
    state_d       = state_q; // [RQ19]
    coast_quick_d = coast_quick_q;
    if (fault_seen) begin
      state_d = power_locked_state; // [RQ17]
    end else begin
      case (state_q)
        power_locked_state: begin
          if (command == cmd_off && enables_ok) begin
            state_d = ready_state; // [RQ2]
          end
        end
        ready_state: begin
          if (command == cmd_coast) begin
            state_d       = coast_state; // [RQ6]
            coast_quick_d = 1'b0;
          end else if (command == cmd_quick) begin
            state_d = quick_state; // [RQ7]
          end else if (command == cmd_on && enables_ok) begin
            state_d = switched_on_state; // [RQ3] [RQ18]
          end
        end
        switched_on_state: begin
          if (command == cmd_coast) begin
            state_d       = coast_state; // [RQ6]
            coast_quick_d = 1'b0;
          end else if (command == cmd_quick) begin
            state_d = quick_state; // [RQ7]
          end else if (!enables_ok || command == cmd_off) begin
            state_d = ready_state; // [RQ5]
          end else if (command == cmd_enable_op) begin
            state_d = operation_state; // [RQ4]
          end
        end
        operation_state: begin
          if (command == cmd_coast) begin
            state_d       = coast_state; // [RQ6]
            coast_quick_d = 1'b0;
          end else if (command == cmd_quick) begin
            state_d = quick_state; // [RQ7]
          end else if (!enables_ok || command == cmd_off) begin
            state_d = ready_state; // [RQ5]
          end else if (command == cmd_on) begin
            state_d = switched_on_state; // [RQ5]
          end
        end
        coast_state: begin
          // only a released coast stop leaves; bit 10 clear is no release
          if (command == cmd_off || command == cmd_on || command == cmd_enable_op) begin
            state_d = power_locked_state;
          end
        end
        quick_state: begin
          if (command == cmd_coast) begin
            state_d       = coast_state; // [RQ6]
            coast_quick_d = 1'b1;
          end else if (command == cmd_off || command == cmd_on || command == cmd_enable_op) begin
            state_d = power_locked_state;
          end
        end
        default: begin
          state_d = power_locked_state;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= power_locked_state;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coast_quick_q <= 1'b0;
    end else begin
      coast_quick_q <= coast_quick_d;
    end
  end

  // ****************************************************************
  // status word
  // ****************************************************************
  logic [15:0] status_q;
  logic [15:0] status_d;

  function automatic logic [15:0] state_status(drive_state_e st, logic from_quick);
    logic [15:0] pat;
    pat = `DRV_ST_LOCKED;
    case (st)
      power_locked_state: pat = `DRV_ST_LOCKED; // [RQ8]
      ready_state:        pat = `DRV_ST_READY; // [RQ2]
      switched_on_state:  pat = `DRV_ST_SWITCHED; // [RQ3]
      operation_state:    pat = `DRV_ST_OPERATION; // [RQ4]
      coast_state:        pat = from_quick ? `DRV_ST_COAST_QUICK : `DRV_ST_COAST; // [RQ6]
      quick_state:        pat = `DRV_ST_QUICK; // [RQ7]
      default:            pat = `DRV_ST_LOCKED;
    endcase
    return pat;
  endfunction : state_status

  // fault flag sits outside the mask, so it never disturbs the pattern
  always_comb begin
    status_d = state_status(state_d, coast_quick_d); // [RQ9]
    if (fault_seen) begin
      status_d = status_d | `DRV_ST_FAULT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `DRV_ST_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  assign link.status_word = status_q;

  // ****************************************************************
  // power stage, controller and brake
  // ****************************************************************
  logic              stage_d;
  logic              stage_q;
  logic              ctrl_q;
  logic              brake_q;
  logic [MODE_W-1:0] mode_q;

  // quick stop keeps the stage on so the stop ramp can brake the motor
  assign stage_d = (state_d == switched_on_state) || (state_d == operation_state) ||
                   (state_d == quick_state);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= 1'b0;
    end else begin
      stage_q <= stage_d; // [RQ3] [RQ6]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 1'b0;
    end else begin
      ctrl_q <= (state_d == operation_state); // [RQ4] [RQ5] [RQ7]
    end
  end

  // brake follows the stage in the same edge, never lags it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brake_q <= 1'b1;
    end else begin
      brake_q <= !stage_d; // [RQ13] [RQ14]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '0;
    end else if (stage_d) begin
      mode_q <= op_mode; // [RQ15]
    end else begin
      mode_q <= '0;
    end
  end

  assign power_stage_on = stage_q;
  assign controller_on  = ctrl_q;
  assign brake_engaged  = brake_q;
  assign active_mode    = mode_q;
  assign drive_state    = state_q;

endmodule : drive_device

`default_nettype wire

// ---- hw/drive_link_if.sv ----
/*
  Link between the fieldbus master end and the drive end.
  Assumes both ends on one clock; the bench joins them.
*/
`timescale 1ns/1ns
`default_nettype none

interface drive_link_if;
  logic [15:0] control_word;
  logic [15:0] status_word;

  modport device (input control_word, output status_word);
  modport master (output control_word, input status_word);
endinterface : drive_link_if

`default_nettype wire

// ---- hw/drive_master.sv ----
/*
  Fieldbus master end: AXI4-Lite registers for software, control word
  issue with read-back confirmation, and the enable sequence.
  Assumes the drive end on the link and an AXI4-Lite master on clk.
*/
`timescale 1ns/1ns
`default_nettype none

module drive_master
  import drive_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  drive_link_if.master     link
);
`include "drive_cfg.svh"

  // ****************************************************************
  // confirmation of the last issued word
  // ****************************************************************
  logic [15:0] cw_q;
  logic        wait_q;
  logic [1:0]  seq_q;
  cmd_e        issued_cmd;
  logic        match;
  logic        busy;

  cmd_decode u_decode (
    .control_word (cw_q),
    .command      (issued_cmd)
  );

  function automatic logic pattern_ok(cmd_e c, logic [15:0] st);
    logic [15:0] m;
    m = st & `DRV_ST_MASK; // [RQ9]
    case (c)
      cmd_off:       return m == `DRV_ST_READY;
      cmd_on:        return m == `DRV_ST_SWITCHED;
      cmd_enable_op: return m == `DRV_ST_OPERATION;
      cmd_coast:     return (m == `DRV_ST_COAST) || (m == `DRV_ST_COAST_QUICK);
      cmd_quick:     return m == `DRV_ST_QUICK;
      default:       return 1'b1;
    endcase
  endfunction : pattern_ok

  assign match = pattern_ok(issued_cmd, link.status_word);
  assign busy  = wait_q && !match; // [RQ10]

  // ****************************************************************
  // write channel
  // ****************************************************************
  logic        aw_full_q;
  logic        w_full_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        wr_fire;
  logic        cmd_wr;
  logic        seq_wr;
  logic        wr_ok;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign wr_fire       = aw_full_q && w_full_q && !bvalid_q;
  // coast stop is never refused, a safe stop must always get through
  assign cmd_wr = wr_fire && aw_addr_q == `CTL_REG_CMD && w_data_q[`DRV_CW_NOCOAST_BIT] == 1'b0 ||
                  wr_fire && aw_addr_q == `CTL_REG_CMD && !busy && seq_q == 2'h0;
  assign seq_wr = wr_fire && aw_addr_q == `CTL_REG_SEQ && w_data_q[0] && !busy && seq_q == 2'h0;
  assign wr_ok  = cmd_wr || seq_wr || (wr_fire && aw_addr_q == `CTL_REG_SEQ && !w_data_q[0]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[3:2], 2'h0};
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ****************************************************************
  // control word issue and enable sequence
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cw_q   <= `DRV_CW_RESET;
      wait_q <= 1'b0;
      seq_q  <= 2'h0;
    end else if (cmd_wr) begin
      cw_q   <= `DRV_CW_BASE | {12'h000, w_data_q[3:0]}; // [RQ11] [RQ16]
      wait_q <= 1'b1;
      seq_q  <= 2'h0;
    end else if (seq_wr) begin
      cw_q   <= `DRV_CW_BASE | 16'h0006; // [RQ12]
      wait_q <= 1'b1;
      seq_q  <= 2'h1;
    end else if (wait_q && match) begin
      wait_q <= 1'b0;
      if (seq_q == 2'h1) begin
        cw_q   <= `DRV_CW_BASE | 16'h0007; // [RQ12]
        wait_q <= 1'b1;
        seq_q  <= 2'h2;
      end else if (seq_q == 2'h2) begin
        cw_q   <= `DRV_CW_BASE | 16'h000f; // [RQ12]
        wait_q <= 1'b1;
        seq_q  <= 2'h3;
      end else begin
        seq_q <= 2'h0;
      end
    end
  end

  assign link.control_word = cw_q;

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `AXI_RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'h0})
        `CTL_REG_CMD:    rdata_q <= {16'h0000, cw_q};
        `CTL_REG_STATUS: rdata_q <= {13'h0000, seq_q != 2'h0, busy, wait_q, link.status_word};
        `CTL_REG_SEQ:    rdata_q <= {30'h0, seq_q};
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= `AXI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : drive_master

`default_nettype wire

// ---- hw/drive_pkg.sv ----
/*
  Types shared by both ends of the drive control link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package drive_pkg;

  typedef enum logic [2:0] {
    power_locked_state,
    ready_state,
    switched_on_state,
    operation_state,
    coast_state,
    quick_state
  } drive_state_e;

  typedef enum logic [2:0] {
    cmd_none,
    cmd_off,
    cmd_on,
    cmd_enable_op,
    cmd_coast,
    cmd_quick
  } cmd_e;

endpackage : drive_pkg

// ---- sim/drive_link_sva.sv ----
/* checker: masked status answers on the drive link.
   assumes the bench puts it beside the link, pins in view. */
`timescale 1ns/1ns
`default_nettype none
module drive_link_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] control_word,
  input wire logic [15:0] status_word,
  input wire logic        power_enable_pin,
  input wire logic        controller_enable_pin,
  input wire logic        fault_pin
);
  // ****
  // helpers
  // ****
  logic [3:0]  ok_q;
  logic [15:0] m;
  logic [3:0]  c;
  logic        q;
  assign m = status_word & 16'h0277;
  assign c = control_word[3:0];
  // pins cross a two-flop sync, so look four cycles back
  assign q = (&ok_q) && control_word[10];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ok_q <= 4'h0;
    else ok_q <= {ok_q[2:0], power_enable_pin & controller_enable_pin & !fault_pin};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // properties
  // ****
  property p_rst; $rose(rst_n) |-> m == 16'h0240; endproperty
  a_rst: assert property (p_rst) else $error("not locked after reset");
  property p_hold; q && m == 16'h0240 && c[2:0] != 3'b110 |=> m == 16'h0240; endproperty
  a_hold: assert property (p_hold) else $error("locked state left");
  property p_off; q && c[2:0] == 3'b110 && (m == 16'h0240 || m[0]) |=> m == 16'h0201; endproperty
  a_off: assert property (p_off) else $error("off missed ready");
  property p_on; q && c == 4'h7 && (m == 16'h0201 || m == 16'h0207) |=> m == 16'h0203; endproperty
  a_on: assert property (p_on) else $error("on missed switched");
  property p_enop; q && c == 4'hf && m == 16'h0203 |=> m == 16'h0207; endproperty
  a_enop: assert property (p_enop) else $error("enable missed operation");
  property p_coast; q && !c[1] && !m[4] && (m[0] || m == 16'h0260) |=>
    m == ($past(m) == 16'h0260 ? 16'h0270 : 16'h0250); endproperty
  a_coast: assert property (p_coast) else $error("coast status wrong");
  property p_quick; q && c[2:1] == 2'b01 && m[0] |=> m == 16'h0260; endproperty
  a_quick: assert property (p_quick) else $error("quick status wrong");
  property p_stay; q && m == 16'h0201 && c == 4'hf |=> $stable(m); endproperty
  a_stay: assert property (p_stay) else $error("unmatched code moved");
  property p_leave; q && c[2:1] == 2'b11 && m[6] && m[5:4] != 2'b00 |=> m == 16'h0240; endproperty
  a_leave: assert property (p_leave) else $error("stop not left");
endmodule : drive_link_sva
`default_nettype wire

// ---- sim/testbench.sv ----
/* bench: both link ends, driven over axi4-lite.
   assumes one 100 MHz clock; pins driven directly. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import drive_pkg::*;
  logic clk, rst_n, pen, cen, flt, pso, con, brk;
  logic [3:0] op_mode, act, awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, sd;
  logic [1:0] bresp, rresp, r;
  logic [15:0] em, ecw, cwl;
  logic [15:0] cwq[$];
  logic eb;
  drive_state_e dst;
  int n_mismatch, num_checks;
  drive_link_if lnk();
  drive_master u_drive_master (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(lnk));
  drive_device u_drive_device (.clk(clk), .rst_n(rst_n), .link(lnk),
    .power_enable_pin(pen), .controller_enable_pin(cen), .fault_pin(flt),
    .op_mode(op_mode), .power_stage_on(pso), .controller_on(con),
    .brake_engaged(brk), .active_mode(act), .drive_state(dst));
  drive_link_sva u_drive_link_sva (.clk(clk), .rst_n(rst_n),
    .control_word(lnk.control_word), .status_word(lnk.status_word),
    .power_enable_pin(pen), .controller_enable_pin(cen), .fault_pin(flt));
  // ****
  // bus tasks and model
  // ****
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task axw(logic [3:0] a, logic [31:0] v);
    logic aw_on, w_on;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    aw_on = 1;
    w_on = 1;
    // local flags: the valids only settle after this time step
    while (aw_on || w_on) begin
      @(posedge clk);
      if (aw_on && awready) begin
        awvalid <= 0;
        aw_on = 0;
      end
      if (w_on && wready) begin
        wvalid <= 0;
        w_on = 0;
      end
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 0;
  endtask : axw
  task axr(logic [3:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    sd = rdata; r = rresp;
    rready <= 0;
  endtask : axr
  task settle();
    repeat (8) begin
      axr(4'h4);
      if (!sd[16]) break;
    end
  endtask : settle
  function automatic logic [15:0] nx(logic [15:0] m, logic [3:0] c);
    for (int i = 0; i < 3; i++) begin
      if (!c[1]) m = (m == 16'h0240) ? m : (m == 16'h0260) ? 16'h0270 : m[6] ? m : 16'h0250;
      else if (!c[2]) m = m[6] ? m : 16'h0260;
      else if (m[6] && m != 16'h0240) m = 16'h0240;
      else if (!c[0]) m = 16'h0201;
      else if (!c[3]) m = (m == 16'h0201 || m == 16'h0207) ? 16'h0203 : m;
      else m = (m == 16'h0203) ? 16'h0207 : m;
    end
    return m;
  endfunction : nx
  function automatic logic cf(logic [15:0] m, logic [3:0] c);
    if (!c[1]) return m == 16'h0250 || m == 16'h0270;
    if (!c[2]) return m == 16'h0260;
    if (!c[0]) return m == 16'h0201;
    return m == (c[3] ? 16'h0207 : 16'h0203);
  endfunction : cf
  function automatic drive_state_e st_of(logic [15:0] m);
    case (m)
      16'h0201: return ready_state;
      16'h0203: return switched_on_state;
      16'h0207: return operation_state;
      16'h0260: return quick_state;
      16'h0250, 16'h0270: return coast_state;
      default: return power_locked_state;
    endcase
  endfunction : st_of
  task chk_all();
    logic on;
    on = em == 16'h0203 || em == 16'h0207 || em == 16'h0260;
    chk("state", st_of(em), dst);
    chk("status", em, sd[15:0] & 16'h0277);
    chk("busy", eb, sd[17]);
    chk("cw", ecw, lnk.control_word);
    chk("stage", on, pso);
    chk("brake", !on, brk);
    chk("ctrl", em == 16'h0207, con);
    chk("mode", on ? op_mode : 4'h0, act);
  endtask : chk_all
  // locked takes off codes only, stop states leave on off codes only, else the master waits forever
  task cmd(logic [3:0] c);
    logic rf;
    if (em == 16'h0240) c[2:0] = 3'b110;
    else if (em[6] && c[2:1] == 2'b11) c[0] = 1'b0;
    rf = eb && c[1];
    axw(4'h0, {$urandom} & 32'hfff0 | c);
    chk("bresp", rf ? 2'h2 : 2'h0, r);
    if (!rf) begin
      em = nx(em, c); eb = !cf(em, c); ecw = 16'h0400 | c;
    end
    settle();
    chk_all();
  endtask : cmd
  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // ****
  // run
  // ****
  always @(posedge clk) if (lnk.control_word !== cwl) begin
    cwq.push_back(lnk.control_word);
    cwl = lnk.control_word;
  end
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    logic [3:0] tc[10] = '{4'h6, 4'hf, 4'h7, 4'hf, 4'h6, 4'hb, 4'h5, 4'he, 4'hf, 4'h7};
    rst_n = 0; pen = 1; cen = 1; flt = 0; op_mode = 4'h3; wstrb = 4'hf;
    awaddr = 0; araddr = 0; wdata = 0; awvalid = 0; wvalid = 0;
    bready = 0; arvalid = 0; rready = 0; n_mismatch = 0; num_checks = 0;
    em = 16'h0240; eb = 0; ecw = 16'h0400;
    void'($urandom(45));
    repeat (12) @(posedge clk);
    rst_n <= 1;
    axr(4'h4);
    chk_all();
    axr(4'hc);
    chk("rresp", 2'h2, r);
    chk("rdata", 0, sd);
    axw(4'h4, 1);
    chk("bresp", 2'h2, r);
    axw(4'h8, 0);
    chk("seq idle", 2'h0, r);
    foreach (tc[i]) cmd(tc[i]);
    cmd(4'h0);
    cmd(4'he);
    cen <= 0;
    axw(4'h0, 7);
    chk("bresp", 2'h0, r);
    settle();
    eb = 1; ecw = 16'h0407;
    chk_all();
    cen <= 1;
    settle();
    em = 16'h0203; eb = 0;
    chk_all();
    repeat (40) begin
      op_mode <= 4'($urandom);
      cmd(4'($urandom));
    end
    cmd(4'h0);
    cmd(4'he);
    cen <= 0;
    cwq.delete();
    axw(4'h8, 1);
    chk("seq", 2'h0, r);
    axw(4'h8, 1);
    chk("seq busy", 2'h2, r);
    axw(4'h0, 7);
    chk("cmd busy", 2'h2, r);
    cen <= 1;
    repeat (20) begin
      axr(4'h8);
      if (sd[1:0] == 2'h0) break;
    end
    settle();
    em = 16'h0207; ecw = 16'h040f;
    chk_all();
    foreach (tc[i]) if (i < 3) chk("seq cw", {tc[0], tc[2], tc[1]} >> (8 - 4 * i) & 4'hf | 16'h0400, cwq[i]);
    flt <= 1;
    repeat (3) axr(4'h4);
    chk("fault", 16'h0248, sd[15:0]);
    chk("brake", 1, brk);
    chk("state", power_locked_state, dst);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
